// ===== timer_pkg.sv
// Purpose: constants shared by the standard timer block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   control bit positions follow the two control registers
package timer_pkg;

  // register byte addresses
  localparam logic [11:0] CTRL0_ADDR   = 12'h000;
  localparam logic [11:0] CTRL1_ADDR   = 12'h004;
  localparam logic [11:0] CNT_LO_ADDR  = 12'h008;
  localparam logic [11:0] CNT_HI_ADDR  = 12'h00C;
  localparam logic [11:0] CMPA_LO_ADDR = 12'h010;
  localparam logic [11:0] CMPA_HI_ADDR = 12'h014;
  localparam logic [11:0] FLAGS_ADDR   = 12'h018;

  // reset values
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [9:0] CMPA_RESET  = 10'h000;
  localparam logic [9:0] CNT_RESET   = 10'h000;

  // control zero fields
  localparam int PAUSE_BIT   = 7;
  localparam int CKSEL_LSB   = 4;
  localparam int ON_BIT      = 3;
  localparam int PERIOD_LSB  = 0;

  // control one fields
  localparam int MODE_LSB    = 6;
  localparam int PINFN_LSB   = 4;
  localparam int INITLVL_BIT = 3;
  localparam int POL_BIT     = 2;
  localparam int SWAP_BIT    = 1;
  localparam int CLRSRC_BIT  = 0;

  // flag register fields
  localparam int FLAG_A_BIT  = 0;
  localparam int FLAG_P_BIT  = 1;

  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;

  // clock source codes
  localparam logic [2:0] CK_SYS4  = 3'h0;
  localparam logic [2:0] CK_SYS   = 3'h1;
  localparam logic [2:0] CK_H16   = 3'h2;
  localparam logic [2:0] CK_H64   = 3'h3;
  localparam logic [2:0] CK_SUB0  = 3'h4;
  localparam logic [2:0] CK_SUB1  = 3'h5;
  localparam logic [2:0] CK_EXTR  = 3'h6;
  localparam logic [2:0] CK_EXTF  = 3'h7;

  // prescaler divide counts
  localparam int DIV_SYS4 = 4;
  localparam int DIV_H16  = 16;
  localparam int DIV_H64  = 64;

  // one period step in timer clocks
  localparam logic [10:0] PERIOD_STEP = 11'h080;
  localparam logic [10:0] FULL_PERIOD = 11'h400;

endpackage : timer_pkg

// ===== edge_sync.sv
// Purpose: three-stage synchroniser with rising and falling edge pulses
// Assumes: asynchronous pin input
// Notes:   edges are taken from stages two and three only
module edge_sync
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // pin
  input  wire logic pin_in,
  // edges
  output logic      rise,
  output logic      fall
);

  logic [2:0] sync_r;
  logic       level_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_r <= 3'h0;
    else
      sync_r <= {sync_r[1:0], pin_in};
  end

  // a new level only counts once stages two and three agree on it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      level_r <= 1'b0;
    else if (sync_r[1] == sync_r[2])
      level_r <= sync_r[2];
  end

  assign rise = (sync_r[1] == sync_r[2]) & sync_r[2] & ~level_r;
  assign fall = (sync_r[1] == sync_r[2]) & ~sync_r[2] & level_r;

endmodule : edge_sync

// ===== standard_timer.sv
// Purpose: 10-bit standard timer with compare, PWM and counter modes
// Assumes: APB slave, clk 40 MHz, high and sub clocks enter as enables
// Notes:   single pulse starts on counter_on rise, ends on compare A
//
// How it works
// - 10-bit up counter on selected clock
// - period compares bits 9-7, A compares all
// - on rise clears counter, off holds it
// - cleared only by on rise, overflow or match
// - pause holds value, resumes from it
// - clock select chooses timer tick source
// - period 0 means 1024, else n*128
// - clear source picks A or P/overflow
// - clear source ignored in PWM mode
// - mode field: compare, PWM, counter
// - compare A match drives pin per function
// - PWM mode pin function: force, PWM, pulse
// - pin changes only if level differs
// - on rise restores initial pin level
// - initial level bit sets level or polarity
// - polarity bit inverts pin output
// - swap bit exchanges period and duty
// - inverted copy of the output pin
// - counter mode does not drive pin
// - clear by A suppresses P flag
// - clear by P raises both flags
// - in compare mode only compare A moves the pin
// - duty at or above period gives full
module standard_timer
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock enables from other clock sources
  input  wire logic        high_clock_tick,
  input  wire logic        sub_clock_tick,
  // pins
  input  wire logic        external_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_pin_inverted,
  output logic             timer_output_enable,
  // events
  output logic             compare_a_flag,
  output logic             compare_p_flag
);

  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [9:0] cmpa_r;
  logic [9:0] cnt_r;
  logic       on_d_r;
  logic       out_r;
  logic       flag_a_r;
  logic       flag_p_r;
  logic       ev_a_r;
  logic       ev_p_r;
  logic       pulse_r;
  logic [5:0] pre_r;
  logic [5:0] hdiv_r;
  logic       ext_rise;
  logic       ext_fall;
  logic       tick;
  logic       h16_tick;
  logic       h64_tick;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  wire        pause_control       = ctrl0_r[PAUSE_BIT];
  wire [2:0]  clock_source_select = ctrl0_r[CKSEL_LSB +: 3];
  wire        counter_on_control  = ctrl0_r[ON_BIT];
  wire [2:0]  period_compare_value = ctrl0_r[PERIOD_LSB +: 3];
  wire [1:0]  operating_mode_select = ctrl1_r[MODE_LSB +: 2];
  wire [1:0]  output_pin_function = ctrl1_r[PINFN_LSB +: 2];
  wire        output_initial_level = ctrl1_r[INITLVL_BIT];
  wire        output_polarity_invert = ctrl1_r[POL_BIT];
  wire        duty_period_swap    = ctrl1_r[SWAP_BIT];
  wire        clear_source_select = ctrl1_r[CLRSRC_BIT];

  wire        on_rise = counter_on_control & ~on_d_r;
  wire        pwm_mode = (operating_mode_select == MODE_PWM);
  wire        cmp_mode = (operating_mode_select == MODE_CMP);

  // external pin path
  edge_sync u_ext_sync
  (
    .clk     (clk),
    .reset_n (reset_n),
    .pin_in  (external_clock_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // apb access, zero wait state
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr == CTRL0_ADDR) || (paddr == CTRL1_ADDR) ||
                   (paddr == CNT_LO_ADDR) || (paddr == CNT_HI_ADDR) ||
                   (paddr == CMPA_LO_ADDR) || (paddr == CMPA_HI_ADDR) ||
                   (paddr == FLAGS_ADDR);
  assign pslverr = psel & penable & ~addr_ok;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl0_r <= CTRL0_RESET;
      ctrl1_r <= CTRL1_RESET;
      cmpa_r  <= CMPA_RESET;
    end
    else if (wr_en && pstrb[0])
    begin
      case (paddr)
        CTRL0_ADDR:   ctrl0_r <= pwdata[7:0];
        CTRL1_ADDR:   ctrl1_r <= pwdata[7:0];
        CMPA_LO_ADDR: cmpa_r[7:0] <= pwdata[7:0];
        CMPA_HI_ADDR: cmpa_r[9:8] <= pwdata[1:0];
        default:      ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        CTRL0_ADDR:   prdata <= {24'h000000, ctrl0_r};
        CTRL1_ADDR:   prdata <= {24'h000000, ctrl1_r};
        CNT_LO_ADDR:  prdata <= {24'h000000, cnt_r[7:0]};
        CNT_HI_ADDR:  prdata <= {30'h00000000, cnt_r[9:8]};
        CMPA_LO_ADDR: prdata <= {24'h000000, cmpa_r[7:0]};
        CMPA_HI_ADDR: prdata <= {30'h00000000, cmpa_r[9:8]};
        FLAGS_ADDR:   prdata <= {30'h00000000, flag_p_r, flag_a_r};
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // prescalers run free so the tick rate is independent of restarts
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_r <= 6'h00;
    else
      pre_r <= pre_r + 6'h01;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hdiv_r <= 6'h00;
    else if (high_clock_tick)
      hdiv_r <= hdiv_r + 6'h01;
  end

  assign h16_tick = high_clock_tick & (hdiv_r[3:0] == 4'(DIV_H16 - 1));
  assign h64_tick = high_clock_tick & (hdiv_r == 6'(DIV_H64 - 1));

  always_comb
  begin
    case (clock_source_select)
      CK_SYS4: tick = (pre_r[1:0] == 2'(DIV_SYS4 - 1));
      CK_SYS:  tick = 1'b1;
      CK_H16:  tick = h16_tick;
      CK_H64:  tick = h64_tick;
      CK_SUB0,
      CK_SUB1: tick = sub_clock_tick;
      CK_EXTR: tick = ext_rise;
      CK_EXTF: tick = ext_fall;
      default: tick = 1'b0;
    endcase
  end

  // comparators
  wire        match_p = (cnt_r[9:7] == period_compare_value);
  wire        match_a = (cnt_r == cmpa_r);
  wire        run     = counter_on_control & ~pause_control;
  wire        at_max  = (cnt_r == 10'h3FF);
  // period end reached when next tick would leave the period window
  wire [10:0] cnt_nx  = {1'b0, cnt_r} + 11'h001;
  wire [10:0] p_len   = (period_compare_value == 3'h0) ? FULL_PERIOD :
                        11'({period_compare_value, 7'h00});
  wire        p_end   = (cnt_nx == p_len);
  wire        a_end   = match_a & (cmpa_r != 10'h000);
  logic       clr_sel;

  always_comb
  begin
    if (pwm_mode)
      clr_sel = duty_period_swap ? a_end : p_end;
    else if (clear_source_select)
      clr_sel = a_end;
    else
      clr_sel = p_end;
  end

  wire wrap = clr_sel | at_max;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      on_d_r <= 1'b0;
    else
      on_d_r <= counter_on_control;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= CNT_RESET;
    else if (on_rise)
      cnt_r <= CNT_RESET;
    else if (run && tick)
      cnt_r <= wrap ? CNT_RESET : cnt_nx[9:0];
  end

  // flags: one event pulse per counted match
  wire hit_a = run & tick & a_end;
  wire hit_p = run & tick & p_end & (pwm_mode | ~clear_source_select);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ev_a_r <= 1'b0;
      ev_p_r <= 1'b0;
    end
    else
    begin
      ev_a_r <= hit_a;
      ev_p_r <= hit_p;
    end
  end

  // set beats a simultaneous write-one clear
  wire clr_flags = wr_en & pstrb[0] & (paddr == FLAGS_ADDR);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end
    else
    begin
      flag_a_r <= hit_a | (flag_a_r & ~(clr_flags & pwdata[FLAG_A_BIT]));
      flag_p_r <= hit_p | (flag_p_r & ~(clr_flags & pwdata[FLAG_P_BIT]));
    end
  end

  assign compare_a_flag = ev_a_r;
  assign compare_p_flag = ev_p_r;

  // compare output and single pulse latch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      out_r <= 1'b0;
    else if (on_rise)
      out_r <= output_initial_level;
    else if (cmp_mode && hit_a)
    begin
      case (output_pin_function)
        2'h1:    out_r <= 1'b0;
        2'h2:    out_r <= 1'b1;
        2'h3:    out_r <= ~out_r;
        default: out_r <= out_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pulse_r <= 1'b0;
    else if (on_rise)
      pulse_r <= 1'b1;
    else if (hit_a || !counter_on_control)
      pulse_r <= 1'b0;
  end

  // pwm duty: full duty when duty reaches the period
  wire [10:0] duty_len = duty_period_swap ? p_len : {1'b0, cmpa_r};
  wire [10:0] per_len  = duty_period_swap ? {1'b0, cmpa_r} : p_len;
  wire        pwm_act  = (duty_len >= per_len) | ({1'b0, cnt_r} < duty_len);
  logic       act;
  logic       lvl;

  always_comb
  begin
    act = 1'b0;
    case (output_pin_function)
      2'h0:    act = 1'b0;
      2'h1:    act = 1'b1;
      2'h2:    act = pwm_act & counter_on_control;
      2'h3:    act = pulse_r;
      default: act = 1'b0;
    endcase
    if (pwm_mode)
      lvl = output_initial_level ? act : ~act;
    else
      lvl = out_r;
  end

  // registered pin drive
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_output_pin          <= 1'b0;
      timer_output_pin_inverted <= 1'b1;
      timer_output_enable       <= 1'b0;
    end
    else
    begin
      timer_output_pin          <= lvl ^ output_polarity_invert;
      timer_output_pin_inverted <= ~(lvl ^ output_polarity_invert);
      timer_output_enable       <= (operating_mode_select != MODE_TMR);
    end
  end

  // software is expected to stop the timer before mode and pin changes

  property cnt_clear_on_rise;
    @(posedge clk) disable iff (!reset_n) on_rise |=> (cnt_r == 10'h000);
  endproperty
  on_rise_clear_a: assert property (cnt_clear_on_rise) else $error("counter not cleared");

  hold_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!counter_on_control && !on_rise) |=> $stable(cnt_r)) else $error("counter moved while off");

  pause_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pause_control && !on_rise) |=> $stable(cnt_r)) else $error("counter moved in pause");

  count_up_a: assert property (@(posedge clk) disable iff (!reset_n)
    (run && tick && !wrap && !on_rise) |=> (cnt_r == $past(cnt_r) + 10'h001)) else $error("bad count");

  no_p_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!pwm_mode && clear_source_select) |=> !compare_p_flag) else $error("p flag with A clear");

  init_level_a: assert property (@(posedge clk) disable iff (!reset_n)
    (on_rise && cmp_mode) |=> ##1 (timer_output_pin == ($past(output_initial_level, 2) ^ output_polarity_invert)))
    else $error("pin not at initial level");

  inv_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
    timer_output_pin_inverted == ~timer_output_pin) else $error("inverted pin wrong");

  tmr_undriven_a: assert property (@(posedge clk) disable iff (!reset_n)
    (operating_mode_select == MODE_TMR) |=> !timer_output_enable) else $error("pin driven in counter mode");

  p_match_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (run && tick && p_end && !(pwm_mode ? duty_period_swap : clear_source_select) && !on_rise) |=> (cnt_r == 10'h000))
    else $error("no clear on period");

endmodule : standard_timer

// ===== ext_clock_model.sv
// Purpose: far-side model that drives the external count pin
// Assumes: pin idles low between bursts
// Notes:   edges spaced wider than the three-flop synchroniser
module ext_clock_model
(
  // clock
  input  wire logic clk,
  // pin
  output logic      external_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial external_clock_pin = 1'b0;

  task automatic pulses(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk);
      external_clock_pin <= 1'b1;
      repeat (4) @(posedge clk);
      external_clock_pin <= 1'b0;
    end
  endtask : pulses
endmodule : ext_clock_model

// ===== tb_standard_timer.sv
// Purpose: self-checking bench for standard_timer
// Assumes: zero-wait APB slave, tick enables made here
// Notes:   counts checked exactly are read while paused or off so both halves agree
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_standard_timer
  import timer_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err_seen;
  logic        high_clock_tick, sub_clock_tick, external_clock_pin;
  logic        timer_output_pin, timer_output_pin_inverted, timer_output_enable;
  logic        compare_a_flag, compare_p_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [1:0]  sub_div;
  int          num_errors, checked, p_pulses;

  standard_timer dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .high_clock_tick, .sub_clock_tick, .external_clock_pin, .timer_output_pin,
    .timer_output_pin_inverted, .timer_output_enable, .compare_a_flag, .compare_p_flag);
  ext_clock_model ext_model (.clk, .external_clock_pin);

  always #12.5 clk = ~clk;

  // high clock ticks every other cycle, sub clock every fourth
  always @(posedge clk)
  begin
    high_clock_tick <= ~high_clock_tick;
    sub_div         <= sub_div + 2'h1;
    sub_clock_tick  <= (sub_div == 2'h3);
    if (compare_p_flag === 1'b1)
      p_pulses <= p_pulses + 1;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    err_seen = pslverr;
    if (n >= 20)
    begin
      num_errors++;
      complete_run;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_cnt(output logic [9:0] v);
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    v[7:0] = q[7:0];
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    v[9:8] = q[1:0];
  endtask : rd_cnt

  task automatic start(input logic [7:0] c1, input logic [9:0] ca, input logic [7:0] c0);
    apb(1'b1, CTRL0_ADDR, 32'h0); // off before mode or pin changes
    apb(1'b1, CMPA_LO_ADDR, {24'h0, ca[7:0]});
    apb(1'b1, CMPA_HI_ADDR, {30'h0, ca[9:8]});
    apb(1'b1, CTRL1_ADDR, {24'h0, c1});
    apb(1'b1, CTRL0_ADDR, {24'h0, c0});
  endtask : start

  task automatic wait_flag(input logic use_p, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while ((use_p ? compare_p_flag : compare_a_flag) !== 1'b1 && n < 2500);
    if (n >= 2500)
    begin
      num_errors++;
      complete_run;
    end
  endtask : wait_flag

  task automatic gap(input logic use_p, output int g);
    wait_flag(use_p, g);
    wait_flag(use_p, g);
  endtask : gap

  task automatic t_regs;
    apb(1'b0, CTRL0_ADDR, 32'h0);
    `CHK("ctrl0 reset", {24'h0, CTRL0_RESET}, q)
    apb(1'b0, CTRL1_ADDR, 32'h0);
    `CHK("ctrl1 reset", {24'h0, CTRL1_RESET}, q)
    apb(1'b0, CNT_HI_ADDR, 32'h0);
    `CHK("count high reset", {30'h0, CNT_RESET[9:8]}, q)
    apb(1'b0, CMPA_LO_ADDR, 32'h0);
    `CHK("compare low reset", {24'h0, CMPA_RESET[7:0]}, q)
    apb(1'b1, CMPA_LO_ADDR, 32'hFFFF_FFA5);
    apb(1'b1, CMPA_HI_ADDR, 32'hFFFF_FFFF);
    apb(1'b1, CNT_LO_ADDR, 32'h0000_00FF);
    pstrb <= 4'hE;
    apb(1'b1, CMPA_LO_ADDR, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, CMPA_LO_ADDR, 32'h0);
    `CHK("compare low", 32'h0000_00A5, q)
    apb(1'b0, CMPA_HI_ADDR, 32'h0);
    `CHK("compare high", 32'h0000_0003, q)
    apb(1'b0, CNT_LO_ADDR, 32'h0);
    `CHK("count read only", 32'h0, q)
    apb(1'b0, 12'h040, 32'h0);
    `CHK("unmapped error", 1'b1, err_seen)
    `CHK("unmapped data", 32'h0, q)
    $display("test registers done");
  endtask : t_regs

  task automatic t_cmp;
    logic [7:0] c1s [5] = '{8'h39, 8'h29, 8'h19, 8'h09, 8'h21};
    logic       lv [5]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    int         g;
    start(8'h39, 10'h00A, 8'h18);
    repeat (3) @(posedge clk);
    #1;
    `CHK("initial level", 1'b1, timer_output_pin)
    `CHK("pin driven", 1'b1, timer_output_enable)
    p_pulses = 0;
    gap(1'b0, g);
    `CHK("compare A gap", 11, g)
    `CHK("P flags", 0, p_pulses)
    for (int i = 0; i < 5; i++)
    begin
      start(c1s[i], 10'h00A, 8'h18);
      wait_flag(1'b0, g);
      repeat (2) @(posedge clk);
      #1;
      `CHK("pin after match", lv[i], timer_output_pin)
      `CHK("inverse copy", ~timer_output_pin, timer_output_pin_inverted)
    end
    $display("test compare done");
  endtask : t_cmp

  task automatic t_period;
    logic [2:0] pv [3] = '{3'h1, 3'h3, 3'h0};
    logic       lv;
    int         g;
    for (int i = 0; i < 3; i++)
    begin
      start(8'h30, 10'h00A, {4'h1, 1'b1, pv[i]});
      wait_flag(1'b1, g);
      lv = timer_output_pin;
      wait_flag(1'b1, g);
      `CHK("period gap", (pv[i] == 3'h0) ? int'(FULL_PERIOD) : pv[i] * int'(PERIOD_STEP), g)
      `CHK("one toggle per period", ~lv, timer_output_pin)
    end
    gap(1'b0, g);
    `CHK("A gap with P clearing", int'(FULL_PERIOD), g)
    $display("test period done");
  endtask : t_period

  task automatic t_pause;
    logic [9:0] v1, v2;
    start(8'h00, 10'h00A, 8'h18);
    repeat (50) @(posedge clk);
    apb(1'b1, CTRL0_ADDR, 32'h98);
    rd_cnt(v1);
    rd_cnt(v2);
    `CHK("paused count", v1, v2)
    apb(1'b1, CTRL0_ADDR, 32'h18);
    rd_cnt(v2);
    `CHK("resumed count", 1'b1, (v2 > v1) && (v2 - v1 < 10'h010))
    apb(1'b1, CTRL0_ADDR, 32'h10);
    rd_cnt(v1);
    repeat (20) @(posedge clk);
    rd_cnt(v2);
    `CHK("held while off", v1, v2)
    apb(1'b1, CTRL0_ADDR, 32'h18);
    rd_cnt(v2);
    `CHK("cleared on start", 1'b1, v2 < 10'h010)
    $display("test pause done");
  endtask : t_pause

  task automatic t_rates;
    logic [2:0] ck [8] = '{CK_SYS, CK_SYS4, CK_H16, CK_H64, CK_SUB0, CK_SUB1, CK_EXTR, CK_EXTF};
    int         cy [6] = '{400, 400, 640, 1280, 400, 400};
    int         ex [8] = '{400, 100, 20, 10, 100, 100, 5, 5};
    logic [9:0] v1, v2;
    apb(1'b1, CTRL1_ADDR, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, CTRL0_ADDR, 32'h0);
      apb(1'b1, CTRL0_ADDR, {24'h0, 1'b1, ck[i], 4'h8});
      rd_cnt(v1);
      apb(1'b1, CTRL0_ADDR, {24'h0, 1'b0, ck[i], 4'h8});
      if (i < 6)
        repeat (cy[i] - 3) @(posedge clk);
      else
      begin
        ext_model.pulses(5);
        repeat (6) @(posedge clk);
      end
      apb(1'b1, CTRL0_ADDR, {24'h0, 1'b1, ck[i], 4'h8});
      rd_cnt(v2);
      `CHK("ticks counted", ex[i], v2 - v1)
    end
    $display("test clock sources done");
  endtask : t_rates

  task automatic t_pwm;
    logic [7:0] c1s [9] = '{8'hA8, 8'hAC, 8'hA8, 8'h88, 8'h98, 8'hA9, 8'hAA, 8'hA0, 8'hB8};
    logic [9:0] cas [9] = '{10'h020, 10'h020, 10'h0C8, 10'h020, 10'h020, 10'h020, 10'h040, 10'h020, 10'h020};
    int         hs [9]  = '{32, 96, 128, 0, 128, 32, 128, 96, 0};
    int         hi;
    for (int i = 0; i < 9; i++)
    begin
      start(c1s[i], cas[i], 8'h19);
      repeat (4) @(posedge clk);
      #1;
      if (c1s[i][5:4] == 2'h3)
        `CHK("single pulse started", 1'b1, timer_output_pin)
      repeat (256) @(posedge clk);
      hi = 0;
      repeat (128)
      begin
        @(posedge clk);
        #1;
        hi += (timer_output_pin === 1'b1);
      end
      `CHK("high cycles", hs[i], hi)
      `CHK("inverse copy", ~timer_output_pin, timer_output_pin_inverted)
    end
    $display("test pwm done");
  endtask : t_pwm

  task automatic t_timer;
    int g;
    start(8'hC1, 10'h00A, 8'h18);
    // earlier pwm runs left the sticky P flag set
    apb(1'b1, FLAGS_ADDR, 32'h0000_0003);
    repeat (4) @(posedge clk);
    #1;
    `CHK("pin driven", 1'b0, timer_output_enable)
    gap(1'b0, g);
    `CHK("counter mode gap", 11, g)
    apb(1'b0, FLAGS_ADDR, 32'h0);
    `CHK("sticky flags", 32'h0000_0001, q)
    $display("test counter mode done");
  endtask : t_timer

  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    high_clock_tick = 1'b0;
    sub_clock_tick = 1'b0;
    sub_div = 2'h0;
    num_errors = 0;
    checked = 0;
    p_pulses = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_cmp;
    t_period;
    t_pause;
    t_rates;
    t_pwm;
    t_timer;
    complete_run;
  end
endmodule : tb_standard_timer
